// [design/sswd_defs.svh]
`ifndef SSWD_DEFS_SVH
`define SSWD_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------------------
`define SSWD_CLK_PERIOD_NS  20
`define SSWD_MS_IN_NS       1000000
`define SSWD_TICK_CYCLES    (`SSWD_MS_IN_NS / `SSWD_CLK_PERIOD_NS)
`define SSWD_TICK_W         16
`define SSWD_MS_W           11

// ----------------------------------------------------------------------------
// manual reset filter, in ms
// ----------------------------------------------------------------------------
`define SSWD_PB_IGNORE_MS   1
`define SSWD_PB_GUARANTEE_MS 20
`define SSWD_PB_DEBOUNCE_MS 10

// ----------------------------------------------------------------------------
// watchdog and reset periods, in ms
// ----------------------------------------------------------------------------
`define SSWD_WD_GND_MS      150
`define SSWD_WD_OPEN_MS     600
`define SSWD_WD_VCC_MS      1200
`define SSWD_RST_MIN_MS     250
`define SSWD_RST_MS         610
`define SSWD_RST_MAX_MS     1000

// ----------------------------------------------------------------------------
// strobe pulse, in ns and cycles (rounded up)
// ----------------------------------------------------------------------------
`define SSWD_ST_PULSE_NS    75
`define SSWD_ST_PULSE_CYC   ((`SSWD_ST_PULSE_NS + `SSWD_CLK_PERIOD_NS - 1) / `SSWD_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
// synchronisers start at the pin idle levels: manual reset and strobe high
`define SSWD_SYNC_RST       7'h60
`define SSWD_CNT_RST        11'h000

`endif

// [design/sswd_pkg.sv]
`include "sswd_defs.svh"

package sswd_pkg;

	typedef logic [`SSWD_MS_W-1:0] sswd_ms_t;

	typedef enum logic [1:0] {
		SSWD_TD_GND  = 2'h0,
		SSWD_TD_OPEN = 2'h1,
		SSWD_TD_VCC  = 2'h2,
		SSWD_TD_RSVD = 2'h3
	} sswd_td_e;

	typedef enum logic [2:0] {
		ST_RUN     = 3'b001,
		ST_HOLD    = 3'b010,
		ST_STRETCH = 3'b100
	} sswd_state_e;

	// synchronised pin bundle
	typedef struct packed {
		logic     mr_n;
		logic     strobe_n;
		logic     below_5;
		logic     below_10;
		logic     tol_10;
		sswd_td_e td;
	} sswd_pins_s;

endpackage : sswd_pkg

// [design/sswd_timebase.sv]
`timescale 1ns/100ps
`include "sswd_defs.svh"

module sswd_timebase
	import sswd_pkg::*;
#(
	parameter int TICK_CYCLES = `SSWD_TICK_CYCLES
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	output logic      tick_o
);

	localparam logic [`SSWD_TICK_W-1:0] LAST = `SSWD_TICK_W'(TICK_CYCLES - 1);

	logic [`SSWD_TICK_W-1:0] cnt_reg;
	logic [`SSWD_TICK_W-1:0] gap_reg;
	logic                    seen_reg;

	// ------------------------------------------------------------------------
	// one ms tick divider
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= '0;
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick_o  <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			gap_reg  <= '0;
			seen_reg <= 1'b0;
		end else if (tick_o) begin
			gap_reg  <= '0;
			seen_reg <= 1'b1;
		end else begin
			gap_reg <= gap_reg + 1'b1;
		end
	end

	a_tick_spacing: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick_o && seen_reg) |-> (gap_reg == LAST))
		else $error("ms tick spacing wrong");

endmodule : sswd_timebase

// [design/sswd_top.sv]
`timescale 1ns/100ps
`include "sswd_defs.svh"

// Functional notes
// - manual reset lows shorter than 1 ms never cause a reset.
// - manual reset held low 20 ms or more always causes a reset.
// - manual reset is active low and forces both outputs active.
// - timeout select: ground 150 ms, open 600 ms, supply 1.2 s.
// - watchdog timeouts stay inside 62.5-250, 250-1000, 500-2000 ms.
// - tolerance select picks the 5% (low) or 10% (high) undervoltage flag.
// - active-high reset rises on undervoltage, watchdog expiry or manual reset.
// - active-low reset is always the complement of the active-high reset.
// - after the cause clears, reset stays active one reset period.
// - reset period lies between 250 and 1000 ms, typically 610 ms.
// - no falling strobe within the timeout asserts both resets.
// - any falling strobe edge or 75 ns pulse restarts the watchdog.
// - a watchdog expiry holds both resets for the reset period.

module sswd_top
	import sswd_pkg::*;
#(
	parameter int TICK_CYCLES = `SSWD_TICK_CYCLES
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       manual_reset_n_i,
	input  wire logic       watchdog_strobe_n_i,
	input  wire logic [1:0] timeout_select_i,
	input  wire logic       tolerance_select_i,
	input  wire logic       below_5pct_i,
	input  wire logic       below_10pct_i,
	output logic            reset_o,
	output logic            reset_n_o
);

	localparam sswd_ms_t DEB_LAST = `SSWD_MS_W'(`SSWD_PB_DEBOUNCE_MS - 1);
	localparam sswd_ms_t RST_LAST = `SSWD_MS_W'(`SSWD_RST_MS - 1);

	logic [6:0]  sync1_reg;
	logic [6:0]  sync2_reg;
	sswd_pins_s  pins;
	logic        tick;
	logic        strobe_prev_reg;
	logic        strobe_fall;
	logic        supply_low;
	sswd_ms_t    pb_cnt_reg;
	logic        pb_active_reg;
	logic        cause;
	sswd_ms_t    wd_cnt_reg;
	sswd_ms_t    wd_last;
	logic        wd_expire;
	sswd_ms_t    rst_cnt_reg;
	logic        rst_done;
	sswd_state_e state_reg;
	sswd_state_e state_next;

	// ------------------------------------------------------------------------
	// watchdog limit decode
	// ------------------------------------------------------------------------
	function automatic sswd_ms_t wd_limit(input sswd_td_e td);
		case (td)
			SSWD_TD_GND:  wd_limit = `SSWD_MS_W'(`SSWD_WD_GND_MS);
			SSWD_TD_OPEN: wd_limit = `SSWD_MS_W'(`SSWD_WD_OPEN_MS);
			default:      wd_limit = `SSWD_MS_W'(`SSWD_WD_VCC_MS);
		endcase
	endfunction : wd_limit

	// ------------------------------------------------------------------------
	// timebase
	// ------------------------------------------------------------------------
	sswd_timebase #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timebase (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	// ------------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sync1_reg <= `SSWD_SYNC_RST;
			sync2_reg <= `SSWD_SYNC_RST;
		end else begin
			sync1_reg <= {manual_reset_n_i, watchdog_strobe_n_i, below_5pct_i, below_10pct_i,
				tolerance_select_i, timeout_select_i};
			sync2_reg <= sync1_reg;
		end
	end

	assign pins       = sswd_pins_s'(sync2_reg);
	assign supply_low = pins.tol_10 ? pins.below_10 : pins.below_5;
	assign wd_last    = wd_limit(pins.td) - 1'b1;

	// ------------------------------------------------------------------------
	// strobe edge detect
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			// idle level, so no false edge follows reset
			strobe_prev_reg <= 1'b1;
		end else begin
			strobe_prev_reg <= pins.strobe_n;
		end
	end

	assign strobe_fall = strobe_prev_reg && !pins.strobe_n;

	// ------------------------------------------------------------------------
	// manual reset debounce
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pb_cnt_reg    <= `SSWD_CNT_RST;
			pb_active_reg <= 1'b0;
		end else if (pins.mr_n) begin
			pb_cnt_reg    <= `SSWD_CNT_RST;
			pb_active_reg <= 1'b0;
		end else if (tick && !pb_active_reg) begin
			if (pb_cnt_reg == DEB_LAST) begin
				pb_active_reg <= 1'b1;
			end else begin
				pb_cnt_reg <= pb_cnt_reg + 1'b1;
			end
		end
	end

	assign cause = supply_low || pb_active_reg;

	// ------------------------------------------------------------------------
	// watchdog counter
	// ------------------------------------------------------------------------
	assign wd_expire = (state_reg == ST_RUN) && tick && !strobe_fall && (wd_cnt_reg == wd_last);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wd_cnt_reg <= `SSWD_CNT_RST;
		end else if (state_reg != ST_RUN || strobe_fall) begin
			wd_cnt_reg <= `SSWD_CNT_RST;
		end else if (tick) begin
			wd_cnt_reg <= wd_cnt_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// reset period counter
	// ------------------------------------------------------------------------
	assign rst_done = (state_reg == ST_STRETCH) && tick && (rst_cnt_reg == RST_LAST);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rst_cnt_reg <= `SSWD_CNT_RST;
		end else if (state_reg != ST_STRETCH) begin
			rst_cnt_reg <= `SSWD_CNT_RST;
		end else if (tick) begin
			rst_cnt_reg <= rst_cnt_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// reset sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (cause) begin
					state_next = ST_HOLD;
				end else if (wd_expire) begin
					state_next = ST_STRETCH;
				end
			end
			ST_HOLD: begin
				if (!cause) begin
					state_next = ST_STRETCH;
				end
			end
			ST_STRETCH: begin
				if (cause) begin
					state_next = ST_HOLD;
				end else if (rst_done) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_reg <= ST_STRETCH;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			reset_o   <= 1'b1;
			reset_n_o <= 1'b0;
		end else begin
			reset_o   <= (state_next != ST_RUN);
			reset_n_o <= (state_next == ST_RUN);
		end
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_hold_release;
		(state_reg == ST_HOLD) ##1 (state_reg == ST_STRETCH);
	endsequence

	sequence s_expire;
		(state_reg == ST_RUN) && tick && (wd_cnt_reg == wd_last) && !strobe_fall && !cause;
	endsequence

	a_outputs_complement: assert property (reset_o == !reset_n_o)
		else $error("reset outputs not complementary");

	a_cause_forces: assert property (cause |=> reset_o && !reset_n_o)
		else $error("cause did not assert reset");

	a_pb_short_ignored: assert property ($rose(pb_active_reg) |-> $past(pb_cnt_reg) == DEB_LAST && $past(tick))
		else $error("manual reset accepted too early");

	a_pb_guaranteed: assert property (!pins.mr_n && tick && pb_cnt_reg == DEB_LAST |=> pb_active_reg)
		else $error("manual reset not accepted");

	a_hold_stretch: assert property (s_hold_release |-> reset_o && rst_cnt_reg == '0)
		else $error("stretch did not start on release");

	a_stretch_length: assert property ($fell(reset_o) |-> $past(rst_cnt_reg) == RST_LAST && $past(tick))
		else $error("reset period length wrong");

	a_wd_expiry: assert property (s_expire |=> state_reg == ST_STRETCH ##0 reset_o [*3])
		else $error("watchdog expiry did not reset");

	a_wd_restart: assert property (strobe_fall |=> wd_cnt_reg == '0)
		else $error("strobe did not restart watchdog");

	a_release_restart: assert property ($fell(reset_o) |-> wd_cnt_reg == '0)
		else $error("watchdog not restarted on release");

	a_td_limit: assert property (pins.td == SSWD_TD_GND |-> wd_last == `SSWD_MS_W'(`SSWD_WD_GND_MS - 1))
		else $error("timeout select decode wrong");

endmodule : sswd_top

// [dv/sswd_cpu_model.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// processor model: kicks the watchdog every gap + 1 cycles while out of reset
// ----------------------------------------------------------------------------
module sswd_cpu_model (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        reset_n_i,
	input  wire logic        kick_en_i,
	input  wire logic [15:0] kick_gap_i,
	output logic             watchdog_strobe_n_o
);
	logic [15:0] gap_reg;

	// a processor held in reset cannot kick; the count restarts on release
	always_ff @(posedge mclk_i) begin
		if (rst_i || !reset_n_i || !kick_en_i) begin
			gap_reg <= 16'h0000;
		end else begin
			gap_reg <= (gap_reg == kick_gap_i) ? 16'h0000 : gap_reg + 16'h0001;
		end
	end

	// low pulse of 5 cycles ends each gap, longer than the 75 ns minimum
	always_ff @(posedge mclk_i) begin
		if (rst_i || !reset_n_i || !kick_en_i) begin
			watchdog_strobe_n_o <= 1'b1;
		end else begin
			watchdog_strobe_n_o <= !(gap_reg + 16'h0004 >= kick_gap_i);
		end
	end
endmodule : sswd_cpu_model

// [dv/tb_top.sv]
`timescale 1ns/100ps

module tb_top;
	import sswd_pkg::*;

	localparam int TICK = 4;
	localparam int STR  = 610 * TICK;

	logic        mclk_i              = 1'b0;
	logic        rst_i               = 1'b1;
	logic        manual_reset_n_i    = 1'b1;
	logic        watchdog_strobe_n_i;
	logic [1:0]  timeout_select_i    = 2'h0;
	logic        tolerance_select_i  = 1'b0;
	logic        below_5pct_i        = 1'b0;
	logic        below_10pct_i       = 1'b0;
	logic        reset_o;
	logic        reset_n_o;
	logic        kick_en             = 1'b0;
	logic [15:0] kick_gap            = 16'h0190;
	int          err_count           = 0;
	int          n_tests             = 0;

	always #10 mclk_i = ~mclk_i;

	sswd_top #(.TICK_CYCLES(TICK)) sswd_top_inst (
		.mclk_i              (mclk_i),
		.rst_i               (rst_i),
		.manual_reset_n_i    (manual_reset_n_i),
		.watchdog_strobe_n_i (watchdog_strobe_n_i),
		.timeout_select_i    (timeout_select_i),
		.tolerance_select_i  (tolerance_select_i),
		.below_5pct_i        (below_5pct_i),
		.below_10pct_i       (below_10pct_i),
		.reset_o             (reset_o),
		.reset_n_o           (reset_n_o)
	);

	sswd_cpu_model sswd_cpu_model_inst (
		.mclk_i              (mclk_i),
		.rst_i               (rst_i),
		.reset_n_i           (reset_n_o),
		.kick_en_i           (kick_en),
		.kick_gap_i          (kick_gap),
		.watchdog_strobe_n_o (watchdog_strobe_n_i)
	);

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	task automatic results;
		$display("err_count=%0d n_tests=%0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : cyc

	task automatic check_bit(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit

	task automatic check_rng(input string name, input int lo, input int hi, input int got);
		n_tests++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask : check_rng

	task automatic wait_out(input logic v, input int max, output int n);
		n = 0;
		while (reset_o !== v) begin
			cyc(1);
			n++;
			if (n > max) begin
				err_count++;
				$display("CHECK FAILED wait reset_o expected %b seen %b", v, reset_o);
				results();
			end
		end
	endtask : wait_out

	task automatic hold_level(input string name, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			cyc(1);
			if (reset_o !== v) bad = 1'b1;
		end
		check_bit(name, 1'b0, bad);
	endtask : hold_level

	task automatic stretch_ok(input string name);
		int n;
		wait_out(1'b0, STR + 40, n);
		check_rng(name, STR - 4, STR + 12, n);
	endtask : stretch_ok

	always @(negedge mclk_i) begin
		if (rst_i === 1'b0) begin
			n_tests++;
			if (reset_n_o !== ~reset_o) begin
				err_count++;
				$display("CHECK FAILED reset_n_o expected %b seen %b", ~reset_o, reset_n_o);
			end
		end
	end

	// ------------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------------
	task automatic t_power_on;
		check_bit("reset_o after release", 1'b1, reset_o);
		stretch_ok("power-on stretch");
	endtask : t_power_on

	task automatic t_watchdog;
		int lim[4] = '{150, 600, 1200, 1200};
		int n;
		for (int s = 0; s < 4; s++) begin
			wait_out(1'b1, lim[s] * TICK + 40, n);
			check_rng("watchdog timeout", lim[s] * TICK - 4, lim[s] * TICK + 8, n);
			timeout_select_i = (s == 3) ? 2'h0 : 2'(s + 1);
			wait_out(1'b0, STR + 40, n);
			check_rng("watchdog hold", STR - 8, STR + 8, n);
		end
	endtask : t_watchdog

	task automatic t_kick;
		int n;
		kick_en = 1'b1;
		hold_level("kicked watchdog quiet", 1'b0, 1600);
		kick_en = 1'b0;
		wait_out(1'b1, 150 * TICK + 40, n);
		check_rng("expiry after kicks stop", 150 * TICK - 420, 150 * TICK + 8, n);
		kick_en = 1'b1;
		stretch_ok("expiry stretch");
	endtask : t_kick

	task automatic t_manual;
		int n;
		manual_reset_n_i = 1'b0;
		cyc(3);
		manual_reset_n_i = 1'b1;
		hold_level("short manual low ignored", 1'b0, 80);
		manual_reset_n_i = 1'b0;
		wait_out(1'b1, 100, n);
		check_rng("manual accept", 36, 84, n);
		cyc(40);
		manual_reset_n_i = 1'b1;
		stretch_ok("manual stretch");
	endtask : t_manual

	task automatic t_supply;
		int n;
		for (int t = 0; t < 2; t++) begin
			tolerance_select_i = t[0];
			below_5pct_i = t[0];
			below_10pct_i = !t[0];
			hold_level("unselected flag ignored", 1'b0, 20);
			below_5pct_i = !t[0];
			below_10pct_i = t[0];
			wait_out(1'b1, 8, n);
			check_rng("supply low response", 1, 4, n);
			hold_level("reset held while low", 1'b1, 50);
			below_5pct_i = 1'b0;
			below_10pct_i = 1'b0;
			stretch_ok("supply stretch");
		end
	endtask : t_supply

	initial begin
		cyc(8);
		rst_i = 1'b0;
		cyc(1);
		t_power_on();
		t_watchdog();
		t_kick();
		t_manual();
		t_supply();
		results();
	end
endmodule : tb_top
